/* File: core/uart_modem_polarity_and_clocking.sv */
// Purpose: UART instance with clock generation, handshake polarity, FIFOs, DMA, IRQ
// Assumes: Source clock pins toggle well below half of clk_sys
// Notes:   Frame is fixed at 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
`include "uart_pol_map.svh"

module uart_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [AW:0]        count
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0]   cnt_reg;
    wire           push = in_valid & in_ready;
    wire           pop  = out_valid & out_ready;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rptr_reg];
    assign count     = cnt_reg;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end else begin
            wptr_reg <= push ? AW'(wptr_reg + 1'b1) : wptr_reg;
            rptr_reg <= pop ? AW'(rptr_reg + 1'b1) : rptr_reg;
            cnt_reg  <= (AW+1)'(cnt_reg + push - pop);
        end
    end
endmodule : uart_fifo

module uart_modem_polarity_and_clocking
    import uart_pol_pkg::*;
#(
    parameter int CHANNEL    = 0,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        sin,
    output logic             sout,
    input  wire logic        cts_n,
    output logic             rts_n,
    input  wire logic        audio_pll,
    input  wire logic        main_pll,
    input  wire logic        aux_pll,
    input  wire logic        usb_phy_high_clock,
    input  wire logic        crystal_24mhz_clock,
    output logic             dma_tx_req,
    input  wire logic        dma_tx_ack,
    output logic             dma_rx_req,
    input  wire logic        dma_rx_ack,
    output logic             irq,
    output logic             irq_tx,
    output logic             irq_rx,
    output logic             irq_err
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    logic [1:0]  rst_sync_reg;
    wire         rst_n = rst_sync_reg[1];
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // Pins pass two flops; the third stage feeds edge detection only
    logic [6:0] pin_s1_reg;
    logic [6:0] pin_s2_reg;
    logic [4:0] src_d_reg;
    wire  [6:0] pins = {cts_n, sin, crystal_24mhz_clock, usb_phy_high_clock,
                        aux_pll, main_pll, audio_pll};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 7'h60;
            pin_s2_reg <= 7'h60;
            src_d_reg  <= 5'h00;
        end else begin
            pin_s1_reg <= pins;
            pin_s2_reg <= pin_s1_reg;
            src_d_reg  <= pin_s2_reg[4:0];
        end
    end
    wire [4:0] src_rise = pin_s2_reg[4:0] & ~src_d_reg;
    wire       rx_s     = pin_s2_reg[5];
    wire       cts_s    = pin_s2_reg[6];

    // Registers
    logic [15:0]  divisor_reg;
    clk_cfg_t     clkcfg_reg;
    logic [31:0]  frac_reg;
    soc_handshake_polarity_cfg_t pol_reg;
    int_bits_t    stat_reg;
    int_bits_t    en_reg;
    logic [2:0]   ctrl_reg;
    logic         wait_reg;
    logic [31:0]  rdata_reg;
    logic         tx_in_ready;
    logic         rx_in_ready;

    // Bus decode; a data write to a full FIFO is stalled by waitrequest
    wire sel_data = (avs_address == `REG_DATA);
    wire stall    = avs_write & sel_data & ~tx_in_ready;
    wire acc      = (avs_read | avs_write) & wait_reg & ~stall;
    wire wr       = acc & avs_write;
    wire rd       = acc & avs_read;
    wire wr_div   = wr & (avs_address == `REG_DIVISOR);
    wire wr_cfg   = wr & (avs_address == `REG_CLKCFG);
    wire wr_frac  = wr & (avs_address == `REG_FRAC);
    wire wr_pol   = wr & (avs_address == `REG_POLCFG);
    wire wr_clr   = wr & (avs_address == `REG_INT_CLR);
    wire wr_en    = wr & (avs_address == `REG_INT_EN);
    wire wr_ctrl  = wr & (avs_address == `REG_CTRL);

    // Handshake polarity per channel index
    wire cts_act  = (cts_s == pol_reg.cts_sel[CHANNEL]);
    wire rts_act  = ctrl_reg[`CTRL_RTS] & rx_in_ready;
    wire rts_pin  = pol_reg.rts_sel[CHANNEL] ? rts_act : ~rts_act;

    // Serial clock: source select, integer divide, fraction or crystal
    wire       is_bt    = (CHANNEL == 0);
    wire [1:0] src_eff  = is_bt ? clkcfg_reg.src : {1'b0, clkcfg_reg.src[0]};
    wire       src_tick = src_rise[src_eff];
    logic [5:0]  div_cnt_reg;
    logic [15:0] frac_acc_reg;
    wire        int_tick = src_tick & (div_cnt_reg == clkcfg_reg.div_m1);
    wire [16:0] frac_sum = {1'b0, frac_acc_reg} + {1'b0, frac_reg[31:16]};
    wire        frac_hit = frac_sum >= {1'b0, frac_reg[15:0]};
    wire        serial_tick = (clkcfg_reg.mode == mode_crystal) ? src_rise[4] :
                              (clkcfg_reg.mode == mode_fraction) ? int_tick & frac_hit :
                              int_tick;
    logic [15:0] baud_cnt_reg;
    wire         os_tick = serial_tick & ((baud_cnt_reg + 16'h0001) >= divisor_reg);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg  <= 6'h00;
            frac_acc_reg <= 16'h0000;
            baud_cnt_reg <= 16'h0000;
        end else begin
            if (src_tick) begin
                div_cnt_reg <= int_tick ? 6'h00 : 6'(div_cnt_reg + 1'b1);
            end
            if (int_tick) begin
                frac_acc_reg <= frac_hit ? 16'(frac_sum - {1'b0, frac_reg[15:0]})
                                         : frac_sum[15:0];
            end
            if (serial_tick) begin
                baud_cnt_reg <= os_tick ? 16'h0000 : 16'(baud_cnt_reg + 1'b1);
            end
        end
    end

    // FIFOs
    logic          tx_out_valid;
    logic [7:0]    tx_out_data;
    logic [CW-1:0] tx_count;
    logic          rx_out_valid;
    logic [7:0]    rx_out_data;
    logic [CW-1:0] rx_count;
    ser_state_t    tx_state_reg;
    ser_state_t    rx_state_reg;
    logic [3:0]    tx_os_reg;
    logic [3:0]    rx_os_reg;
    logic [2:0]    tx_bit_reg;
    logic [2:0]    rx_bit_reg;
    logic [7:0]    tx_sh_reg;
    logic [7:0]    rx_sh_reg;
    wire cts_ok  = ~ctrl_reg[`CTRL_AUTOFLOW] | cts_act;
    wire tx_pop  = (tx_state_reg == ser_idle) & tx_out_valid & cts_ok;
    wire tx_bit_end = os_tick & (tx_os_reg == `OVERSAMPLE_MAX);
    wire rx_bit_end = os_tick & (rx_os_reg == `OVERSAMPLE_MAX);
    wire rx_done = (rx_state_reg == ser_stop) & rx_bit_end;
    wire rx_push = rx_done & rx_s;

    uart_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk       (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (wr & sel_data),
        .in_ready  (tx_in_ready),
        .in_data   (avs_writedata[7:0]),
        .out_valid (tx_out_valid),
        .out_ready (tx_pop),
        .out_data  (tx_out_data),
        .count     (tx_count)
    );
    uart_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk       (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (rx_sh_reg),
        .out_valid (rx_out_valid),
        .out_ready (rd & sel_data),
        .out_data  (rx_out_data),
        .count     (rx_count)
    );

    // Transmitter and receiver share os_tick
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= ser_idle;
            tx_os_reg    <= 4'h0;
            tx_bit_reg   <= 3'h0;
            tx_sh_reg    <= 8'h00;
            sout         <= 1'b1;
        end else begin
            tx_os_reg <= os_tick ? 4'(tx_os_reg + 1'b1) : tx_os_reg;
            case (tx_state_reg)
                ser_idle: if (tx_pop) begin
                    tx_sh_reg    <= tx_out_data;
                    tx_os_reg    <= 4'h0;
                    sout         <= 1'b0;
                    tx_state_reg <= ser_start;
                end
                ser_start: if (tx_bit_end) begin
                    sout         <= tx_sh_reg[0];
                    tx_bit_reg   <= 3'h0;
                    tx_state_reg <= ser_data;
                end
                ser_data: if (tx_bit_end) begin
                    tx_bit_reg <= 3'(tx_bit_reg + 1'b1);
                    tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
                    sout       <= (tx_bit_reg == 3'h7) ? 1'b1 : tx_sh_reg[1];
                    tx_state_reg <= (tx_bit_reg == 3'h7) ? ser_stop : ser_data;
                end
                ser_stop: if (tx_bit_end) begin
                    tx_state_reg <= ser_idle;
                end
                default: tx_state_reg <= ser_idle;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= ser_idle;
            rx_os_reg    <= 4'h0;
            rx_bit_reg   <= 3'h0;
            rx_sh_reg    <= 8'h00;
        end else begin
            rx_os_reg <= os_tick ? 4'(rx_os_reg + 1'b1) : rx_os_reg;
            case (rx_state_reg)
                ser_idle: if (os_tick & ~rx_s) begin
                    rx_os_reg    <= 4'h0;
                    rx_state_reg <= ser_start;
                end
                ser_start: if (os_tick & (rx_os_reg == `RX_MID)) begin
                    // Restart the bit timer so later samples fall mid-bit
                    rx_os_reg    <= 4'h0;
                    rx_bit_reg   <= 3'h0;
                    rx_state_reg <= rx_s ? ser_idle : ser_data;
                end
                ser_data: if (rx_bit_end) begin
                    rx_sh_reg    <= {rx_s, rx_sh_reg[7:1]};
                    rx_bit_reg   <= 3'(rx_bit_reg + 1'b1);
                    rx_state_reg <= (rx_bit_reg == 3'h7) ? ser_stop : ser_data;
                end
                ser_stop: if (rx_bit_end) begin
                    rx_state_reg <= ser_idle;
                end
                default: rx_state_reg <= ser_idle;
            endcase
        end
    end

    // Events: tx drained, byte received, framing error or overrun
    int_bits_t ev;
    assign ev.tx  = (tx_state_reg == ser_stop) & tx_bit_end & ~tx_out_valid;
    assign ev.rx  = rx_push & rx_in_ready;
    assign ev.err = rx_done & (~rx_s | ~rx_in_ready);
    wire int_bits_t clr_bits = wr_clr ? int_bits_t'(avs_writedata[2:0]) : int_bits_t'(3'h0);
    wire int_bits_t pend     = stat_reg & en_reg;

    wire [31:0] rd_mux =
        sel_data ? {24'h0, rx_out_valid ? rx_out_data : 8'h00} :
        (avs_address == `REG_DIVISOR)  ? {16'h0, divisor_reg} :
        (avs_address == `REG_CLKCFG)   ? {22'h0, clkcfg_reg} :
        (avs_address == `REG_FRAC)     ? frac_reg :
        (avs_address == `REG_POLCFG)   ? {22'h0, pol_reg} :
        (avs_address == `REG_STATUS)   ? {16'h0, 2'(tx_count >> 6), tx_count[5:0],
                                          2'(rx_count >> 6), rx_count[5:0]} :
        (avs_address == `REG_INT_STAT) ? {29'h0, stat_reg} :
        (avs_address == `REG_INT_EN)   ? {29'h0, en_reg} :
        (avs_address == `REG_CTRL)     ? {29'h0, ctrl_reg} : 32'h0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divisor_reg <= `DIVISOR_RST;
            clkcfg_reg  <= `CLKCFG_RST;
            frac_reg    <= `FRAC_RST;
            pol_reg     <= `POLCFG_RST;
            en_reg      <= 3'h0;
            ctrl_reg    <= 3'h0;
        end else begin
            divisor_reg <= wr_div ? avs_writedata[15:0] : divisor_reg;
            clkcfg_reg  <= wr_cfg ? clk_cfg_t'(avs_writedata[9:0]) : clkcfg_reg;
            frac_reg    <= wr_frac ? avs_writedata : frac_reg;
            pol_reg     <= wr_pol ? soc_handshake_polarity_cfg_t'(avs_writedata[9:0]) : pol_reg;
            en_reg      <= wr_en ? int_bits_t'(avs_writedata[2:0]) : en_reg;
            ctrl_reg    <= wr_ctrl ? avs_writedata[2:0] : ctrl_reg;
        end
    end

    // Outputs; set beats clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg   <= 3'h0;
            wait_reg   <= 1'b1;
            rdata_reg  <= 32'h0;
            rts_n      <= 1'b1;
            irq        <= 1'b0;
            irq_tx     <= 1'b0;
            irq_rx     <= 1'b0;
            irq_err    <= 1'b0;
            dma_tx_req <= 1'b0;
            dma_rx_req <= 1'b0;
        end else begin
            stat_reg   <= (stat_reg & ~clr_bits) | ev;
            wait_reg   <= ~acc;
            rdata_reg  <= rd ? rd_mux : rdata_reg;
            rts_n      <= rts_pin;
            irq        <= |pend;
            irq_tx     <= pend.tx;
            irq_rx     <= pend.rx;
            irq_err    <= pend.err;
            dma_tx_req <= ctrl_reg[`CTRL_DMA_EN] & tx_in_ready & ~dma_tx_ack;
            dma_rx_req <= ctrl_reg[`CTRL_DMA_EN] & rx_out_valid & ~dma_rx_ack;
        end
    end
    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_req_taken;
        acc;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_bus_answer;
        s_req_taken |=> s_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");
    property p_fifo_bound;
        tx_count <= FIFO_DEPTH && rx_count <= FIFO_DEPTH;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count over depth");
    property p_os_from_serial;
        os_tick |-> serial_tick;
    endproperty
    a_os_from_serial: assert property (p_os_from_serial) else $error("tick w/o serial");
    property p_irq_err;
        (stat_reg.err && en_reg.err) |=> irq_err && irq;
    endproperty
    a_irq_err: assert property (p_irq_err) else $error("error interrupt missing");
    property p_sticky;
        (stat_reg.rx && !clr_bits.rx) |=> stat_reg.rx;
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit lost");
    property p_dma_ack;
        dma_tx_ack |=> !dma_tx_req;
    endproperty
    a_dma_ack: assert property (p_dma_ack) else $error("dma request after ack");
    property p_src_limit;
        (CHANNEL != 0) |-> !src_eff[1];
    endproperty
    a_src_limit: assert property (p_src_limit) else $error("extra source on channel");
    property p_div_wrap;
        int_tick |=> div_cnt_reg == 6'h00;
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap");
    property p_rts_pol;
        ##1 rts_n == ($past(pol_reg.rts_sel[CHANNEL]) ? $past(rts_act) : !$past(rts_act));
    endproperty
    a_rts_pol: assert property (p_rts_pol) else $error("rts polarity wrong");
    property p_cts_gate;
        (ctrl_reg[`CTRL_AUTOFLOW] && cts_s != pol_reg.cts_sel[CHANNEL]) |-> !tx_pop;
    endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("sent while cts inactive");
endmodule : uart_modem_polarity_and_clocking

/* File: core/uart_pol_map.svh */
// Purpose: Register offsets, field positions and reset values of the UART block
// Assumes: 32-bit Avalon-MM word registers at byte addresses
// Notes:   Types live in uart_pol_pkg
`ifndef UART_POL_MAP_SVH
`define UART_POL_MAP_SVH
`define REG_DATA       8'h00
`define REG_DIVISOR    8'h04
`define REG_CLKCFG     8'h08
`define REG_FRAC       8'h0C
`define REG_POLCFG     8'h10
`define REG_STATUS     8'h14
`define REG_INT_STAT   8'h18
`define REG_INT_CLR    8'h1C
`define REG_INT_EN     8'h20
`define REG_CTRL       8'h24
`define CTRL_DMA_EN    0
`define CTRL_RTS       1
`define CTRL_AUTOFLOW  2
`define INT_TX         0
`define INT_RX         1
`define INT_ERR        2
`define DIVISOR_RST    16'h0001
`define CLKCFG_RST     10'h000
`define FRAC_RST       32'h00010001
`define POLCFG_RST     10'h000
`define OVERSAMPLE_MAX 4'hF
`define RX_MID         4'h7
`define FIFO_DEPTH     64
`endif

/* File: core/uart_pol_pkg.sv */
// Purpose: Types shared by the UART block
// Assumes: Field layouts match the offsets in uart_pol_map.svh
// Notes:   Structs are msb first
package uart_pol_pkg;
    typedef enum logic [1:0] {
        src_audio_pll, src_main_pll, src_aux_pll, src_usb_phy_high_clock
    } clk_src_t;
    typedef enum logic [1:0] {mode_integer, mode_fraction, mode_crystal, mode_spare} clk_mode_t;
    typedef struct packed {
        clk_mode_t  mode;
        logic [5:0] div_m1;
        clk_src_t   src;
    } clk_cfg_t;
    typedef struct packed {
        logic [4:0] rts_sel;
        logic [4:0] cts_sel;
    } soc_handshake_polarity_cfg_t;
    typedef struct packed {
        logic err;
        logic rx;
        logic tx;
    } int_bits_t;
    typedef enum {ser_idle, ser_start, ser_data, ser_stop} ser_state_t;
endpackage : uart_pol_pkg

/* File: tb/uart_modem_polarity_and_clocking_tb_top.sv */
// Purpose: Self-checking bench for the UART block over Avalon-MM
// Assumes: One source clock at clk_sys/4 feeds every source pin
// Notes:   Integer divide 1, divisor 1 gives 64 clk_sys cycles a bit
`timescale 1ns/1ps
`include "uart_pol_map.svh"
module uart_modem_polarity_and_clocking_tb_top
    import uart_pol_pkg::*;
;
    logic        clk_sys = 0, rstn = 0, main_pll = 0, cts_level = 0;
    logic [7:0]  avs_address = 0;
    logic        avs_read = 0, avs_write = 0, dma_tx_ack = 0, dma_rx_ack = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic        avs_waitrequest, sout, sin, cts_n, rts_n;
    logic        dma_tx_req, dma_rx_req, irq, irq_tx, irq_rx, irq_err;
    int_bits_t   ib;
    int          fail_count = 0, total_checks = 0, seed = 32'h66c6, n;
    logic [7:0]  exp_q[$];
    logic [7:0]  ra[5] = '{`REG_DIVISOR, `REG_CLKCFG, `REG_FRAC, `REG_POLCFG, 8'h3C};
    logic [31:0] rv[5] = '{32'h1, 32'h0, 32'h00010001, 32'h0, 32'h0};
    assign ib = {irq_err, irq_rx, irq_tx};
    always #2 clk_sys = ~clk_sys;
    always #8 main_pll = ~main_pll;
    uart_modem_polarity_and_clocking dut (
        .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sin(sin), .sout(sout), .cts_n(cts_n),
        .rts_n(rts_n), .audio_pll(main_pll), .main_pll(main_pll), .aux_pll(main_pll),
        .usb_phy_high_clock(main_pll), .crystal_24mhz_clock(main_pll),
        .dma_tx_req(dma_tx_req), .dma_tx_ack(dma_tx_ack), .dma_rx_req(dma_rx_req),
        .dma_rx_ack(dma_rx_ack), .irq(irq), .irq_tx(irq_tx), .irq_rx(irq_rx),
        .irq_err(irq_err));
    uart_peer_model #(.BIT_CYC(64)) peer (
        .clk_sys(clk_sys), .sout(sout), .sin(sin), .cts_level(cts_level), .cts_n(cts_n));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic stall(input int lim);
        n++;
        if (n > lim) begin
            fail_count++;
            $display("Error t=%0t wait ran out", $time);
            give_verdict();
        end
    endtask : stall
    // Request held until a rising edge sees waitrequest low; data taken and released there
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            stall(500);
            @(posedge clk_sys);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wait_irq(input int k);
        n = 0;
        while (ib[k] !== 1'b1) begin
            stall(3000);
            @(posedge clk_sys);
        end
    endtask : wait_irq
    initial begin
        soc_handshake_polarity_cfg_t pol;
        logic [7:0] b;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(32'(rts_n), 32'h1, "rts idle");
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h0);
            check(rd, rv[i], "reset value");
        end
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            pol = 10'($random(seed));
            pol.rts_sel[0] = i[0];
            bus(1'b1, `REG_CTRL, {30'h0, i[1], 1'b0});
            bus(1'b1, `REG_POLCFG, {22'h0, pol});
            bus(1'b0, `REG_POLCFG, 32'h0);
            check(rd, {22'h0, pol}, "polarity readback");
            check(32'(rts_n), 32'(i[1] == i[0]), "rts level");
        end
        $display("test rts polarity done");
        bus(1'b1, `REG_DIVISOR, 32'h1);
        bus(1'b1, `REG_CLKCFG, 32'h1);
        bus(1'b1, `REG_INT_EN, 32'h7);
        bus(1'b1, `REG_POLCFG, 32'h1);
        bus(1'b1, `REG_CTRL, 32'h5);
        for (int i = 0; i < 64; i++) begin
            b = 8'($random(seed));
            exp_q.push_back(b);
            bus(1'b1, `REG_DATA, {24'h0, b});
        end
        bus(1'b0, `REG_STATUS, 32'h0);
        check({24'h0, rd[15:8]}, 32'd64, "tx fill");
        check(32'(dma_tx_req), 32'h0, "dma req when full");
        check(32'(peer.got.size()), 32'h0, "held by cts");
        cts_level <= 1'b1;
        n = 0;
        while (peer.got.size() < 64) begin
            stall(50000);
            @(posedge clk_sys);
        end
        foreach (exp_q[i]) check({24'h0, peer.got[i]}, {24'h0, exp_q[i]}, "tx byte");
        wait_irq(0);
        bus(1'b0, `REG_INT_STAT, 32'h0);
        check({rd[0], irq}, 2'b11, "tx interrupt");
        bus(1'b1, `REG_INT_CLR, 32'h1);
        bus(1'b0, `REG_INT_STAT, 32'h0);
        check(32'(rd[0]), 32'h0, "tx clear");
        check(32'(dma_tx_req), 32'h1, "dma tx req");
        @(posedge clk_sys);
        dma_tx_ack <= 1'b1;
        @(posedge clk_sys);
        dma_tx_ack <= 1'b0;
        @(negedge clk_sys);
        check(32'(dma_tx_req), 32'h0, "dma ack drop");
        bus(1'b1, `REG_CLKCFG, 32'h200);
        b = 8'($random(seed));
        bus(1'b1, `REG_DATA, {24'h0, b});
        n = 0;
        while (peer.got.size() < 65) begin
            stall(2000);
            @(posedge clk_sys);
        end
        check({24'h0, peer.got[64]}, {24'h0, b}, "crystal tx byte");
        $display("test transmit done");
        for (int i = 0; i < 3; i++) begin
            b = 8'($random(seed));
            peer.send(b, 1'b1);
            wait_irq(1);
            check(32'(dma_rx_req), 32'h1, "dma rx req");
            dma_rx_ack <= 1'b1;
            @(posedge clk_sys);
            dma_rx_ack <= 1'b0;
            @(negedge clk_sys);
            check(32'(dma_rx_req), 32'h0, "dma rx ack drop");
            bus(1'b0, `REG_DATA, 32'h0);
            check(rd, {24'h0, b}, "rx byte");
            bus(1'b1, `REG_INT_CLR, 32'h2);
        end
        peer.send(8'hA5, 1'b0);
        wait_irq(2);
        bus(1'b0, `REG_STATUS, 32'h0);
        check({24'h0, rd[7:0]}, 32'h0, "framing drop");
        $display("test receive done");
        give_verdict();
    end
endmodule : uart_modem_polarity_and_clocking_tb_top

/* File: tb/uart_peer_model.sv */
// Purpose: Serial peer at the UART pins, sends and captures 8N1 frames
// Assumes: Fixed bit time in clk_sys cycles
// Notes:   Line rests high between frames, as a UART line idles high
`timescale 1ns/1ps
module uart_peer_model #(
    parameter int BIT_CYC = 64
) (
    input  wire logic clk_sys,
    input  wire logic sout,
    output logic      sin,
    input  wire logic cts_level,
    output logic      cts_n
);
    logic [7:0] got[$];
    assign cts_n = cts_level;
    initial sin = 1'b1;
    // A zero stop bit is only sent when a scenario asks for a framing fault
    task automatic send(input logic [7:0] b, input logic stop);
        @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            sin <= (i == 0) ? 1'b0 : (i == 9) ? stop : b[i-1];
            repeat (BIT_CYC) @(posedge clk_sys);
        end
        sin <= 1'b1;
    endtask : send
    // Mid-bit sampling tolerates a start bit that is slightly short
    always begin
        logic [7:0] b;
        @(negedge sout);
        repeat (BIT_CYC / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_sys);
            b[i] = sout;
        end
        repeat (BIT_CYC) @(posedge clk_sys);
        if (sout === 1'b1) got.push_back(b);
    end
endmodule : uart_peer_model
